/* File: inc/fefp_pkg.sv */
// package: offsets, fields, reset values and types of the flash fault and protection block
package fefp_pkg;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_FLASH_CONFIG = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ERR_CONFIG   = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_FAULT_STATUS = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_REGION_PROT  = 5'h08;

  // ==========================================================================
  // field positions
  localparam int BIT_SINGLE_FAULT = 0;
  localparam int BIT_DOUBLE_FAULT = 1;
  localparam int BIT_IGNORE_SF    = 4;
  localparam int BIT_PROT_OPEN    = 7;
  localparam int BIT_PROT_RSV     = 6;
  localparam int BIT_HI_DIS       = 5;
  localparam int HI_SIZE_MSB      = 4;
  localparam int HI_SIZE_LSB      = 3;
  localparam int BIT_LO_DIS       = 2;
  localparam int LO_SIZE_MSB      = 1;
  localparam int LO_SIZE_LSB      = 0;
  localparam int FAULT_W          = 2;

  // ==========================================================================
  // reset and load values
  localparam logic [DATA_W-1:0]  FLASH_CONFIG_RST = 8'h00;
  localparam logic [FAULT_W-1:0] ERR_CONFIG_RST   = 2'h0;
  localparam logic [FAULT_W-1:0] FAULT_STATUS_RST = 2'h0;
  localparam logic [DATA_W-1:0]  REGION_PROT_RST  = 8'h7f;
  localparam logic [DATA_W-1:0]  PROT_FAULT_VAL   = 8'h7f;
  localparam logic [17:0]        CFG_PROT_ADDR    = 18'h3_ff0c;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic single_err;
    logic double_err;
    logic collide;
  } fefp_rd_rpt_t;

  typedef struct packed {
    logic              valid;
    logic              double_err;
    logic [DATA_W-1:0] data;
  } fefp_cfg_rsp_t;

  typedef enum logic [1:0] {
    LD_REQ,
    LD_WAIT,
    LD_RUN
  } fefp_load_t;

endpackage

/* File: design/fefp_fault_flags.sv */
// sticky single/double fault flags, one-cycle store delay, masked interrupt
`timescale 1ns/1ps
module fefp_fault_flags (
  input  wire logic                                i_clk,
  input  wire logic                                i_rst_n,
  input  wire fefp_pkg::fefp_rd_rpt_t              i_rpt,
  input  wire logic                                i_ignore_sf,
  input  wire logic                                i_clr_wr,
  input  wire logic [fefp_pkg::FAULT_W-1:0]        i_clr_bits,
  input  wire logic [fefp_pkg::FAULT_W-1:0]        i_irq_en,
  output logic      [fefp_pkg::FAULT_W-1:0]        o_flags,
  output logic                                     o_irq
);

  // ==========================================================================
  // fault classification
  wire logic                         dbl_hit;
  wire logic                         sgl_hit;
  wire logic [fefp_pkg::FAULT_W-1:0] set_now;
  wire logic [fefp_pkg::FAULT_W-1:0] clr_now;

  assign dbl_hit = i_rpt.valid & (i_rpt.double_err | i_rpt.collide);
  assign sgl_hit = i_rpt.valid & (i_rpt.collide |
                   (i_rpt.single_err & ~i_rpt.double_err & ~i_ignore_sf));
  assign set_now = {dbl_hit, sgl_hit};
  assign clr_now = i_clr_wr ? i_clr_bits : '0;

  // ==========================================================================
  // store stage and sticky flags
  logic [fefp_pkg::FAULT_W-1:0] pend_q;
  logic [fefp_pkg::FAULT_W-1:0] flag_q;
  logic [fefp_pkg::FAULT_W-1:0] flag_d;

  assign flag_d = (flag_q & ~clr_now) | pend_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= fefp_pkg::FAULT_STATUS_RST;
      flag_q <= fefp_pkg::FAULT_STATUS_RST;
    end else begin
      pend_q <= set_now;
      flag_q <= flag_d;
    end
  end

  assign o_flags = flag_q;
  assign o_irq   = |(flag_q & i_irq_en);

endmodule

/* File: design/fefp_top.sv */
// flash fault status, access collision report and region protection register
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - an uncorrectable two-bit read error sets the double fault flag, status bit 1
// - writing one clears the double fault flag; writing zero leaves it
// - a corrected one-bit error sets status bit 0 unless single faults are ignored
// - writing one clears the single fault flag; writing zero leaves it
// - one ECC error sets single or double flag, never both
// - reading a block busy with a command sets both flags
// - flags are stored one clock after the read that caused them
// - protection register at offset 8 selects sectors locked against program and erase
// - protection writes are taken only if the protected region does not shrink
// - after reset is released the protection byte is loaded from configuration address 0x3_FF0C
// - a double fault on that load clears the open bit and sets the rest
// - error interrupt is raised when a set flag has its enable set
module fefp_top (
  input  wire logic                              i_clk,
  input  wire logic                              i_arst_n,
  input  wire logic [fefp_pkg::ADDR_W-1:0]       i_addr,
  input  wire logic [fefp_pkg::DATA_W-1:0]       i_wdata,
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  output logic      [fefp_pkg::DATA_W-1:0]       o_rdata,
  input  wire fefp_pkg::fefp_rd_rpt_t            i_rd_rpt,
  output logic                                   o_cfg_rd_req,
  output logic      [17:0]                       o_cfg_rd_addr,
  input  wire fefp_pkg::fefp_cfg_rsp_t           i_cfg_rsp,
  output logic      [fefp_pkg::DATA_W-1:0]       o_region_protect,
  output logic                                   o_prot_loaded,
  output logic                                   o_irq
);

  // ==========================================================================
  // protection growth check
  function automatic logic prot_grows(input logic [fefp_pkg::DATA_W-1:0] old_v,
                                      input logic [fefp_pkg::DATA_W-1:0] new_v);
    logic ok;
    logic [1:0] old_hs;
    logic [1:0] new_hs;
    logic [1:0] old_ls;
    logic [1:0] new_ls;
    ok     = 1'b1;
    old_hs = old_v[fefp_pkg::HI_SIZE_MSB:fefp_pkg::HI_SIZE_LSB];
    new_hs = new_v[fefp_pkg::HI_SIZE_MSB:fefp_pkg::HI_SIZE_LSB];
    old_ls = old_v[fefp_pkg::LO_SIZE_MSB:fefp_pkg::LO_SIZE_LSB];
    new_ls = new_v[fefp_pkg::LO_SIZE_MSB:fefp_pkg::LO_SIZE_LSB];
    if (old_v[fefp_pkg::BIT_PROT_OPEN]) begin
      // open: fields name protected ranges
      if (!new_v[fefp_pkg::BIT_PROT_OPEN]) begin
        ok = new_v[fefp_pkg::BIT_HI_DIS] & new_v[fefp_pkg::BIT_LO_DIS];
      end else begin
        if (!old_v[fefp_pkg::BIT_HI_DIS]) begin
          ok = ok & ~new_v[fefp_pkg::BIT_HI_DIS] & (new_hs >= old_hs);
        end
        if (!old_v[fefp_pkg::BIT_LO_DIS]) begin
          ok = ok & ~new_v[fefp_pkg::BIT_LO_DIS] & (new_ls >= old_ls);
        end
      end
    end else begin
      // closed: fields name unprotected windows
      if (new_v[fefp_pkg::BIT_PROT_OPEN]) begin
        ok = 1'b0;
      end else begin
        if (!new_v[fefp_pkg::BIT_HI_DIS]) begin
          ok = ok & ~old_v[fefp_pkg::BIT_HI_DIS] & (new_hs <= old_hs);
        end
        if (!new_v[fefp_pkg::BIT_LO_DIS]) begin
          ok = ok & ~old_v[fefp_pkg::BIT_LO_DIS] & (new_ls <= old_ls);
        end
      end
    end
    return ok;
  endfunction

  // ==========================================================================
  // reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ==========================================================================
  // address decode
  wire logic sel_config;
  wire logic sel_err_cfg;
  wire logic sel_status;
  wire logic sel_prot;
  wire logic wr_config;
  wire logic wr_err_cfg;
  wire logic wr_status;
  wire logic wr_prot;

  assign sel_config  = (i_addr == fefp_pkg::OFS_FLASH_CONFIG);
  assign sel_err_cfg = (i_addr == fefp_pkg::OFS_ERR_CONFIG);
  assign sel_status  = (i_addr == fefp_pkg::OFS_FAULT_STATUS);
  assign sel_prot    = (i_addr == fefp_pkg::OFS_REGION_PROT);
  assign wr_config   = i_wr & sel_config;
  assign wr_err_cfg  = i_wr & sel_err_cfg;
  assign wr_status   = i_wr & sel_status;
  assign wr_prot     = i_wr & sel_prot;

  // ==========================================================================
  // configuration registers
  logic                         ignore_sf_q;
  logic [fefp_pkg::FAULT_W-1:0] irq_en_q;

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ignore_sf_q <= fefp_pkg::FLASH_CONFIG_RST[fefp_pkg::BIT_IGNORE_SF];
      irq_en_q    <= fefp_pkg::ERR_CONFIG_RST;
    end else begin
      if (wr_config) begin
        ignore_sf_q <= i_wdata[fefp_pkg::BIT_IGNORE_SF];
      end
      if (wr_err_cfg) begin
        irq_en_q <= i_wdata[fefp_pkg::FAULT_W-1:0];
      end
    end
  end

  // ==========================================================================
  // fault flags
  logic [fefp_pkg::FAULT_W-1:0] flags;
  logic                         irq;

  fefp_fault_flags u_flags (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n_q),
    .i_rpt       (i_rd_rpt),
    .i_ignore_sf (ignore_sf_q),
    .i_clr_wr    (wr_status),
    .i_clr_bits  (i_wdata[fefp_pkg::FAULT_W-1:0]),
    .i_irq_en    (irq_en_q),
    .o_flags     (flags),
    .o_irq       (irq)
  );

  assign o_irq = irq;

  // ==========================================================================
  // protection load sequence
  fefp_pkg::fefp_load_t ld_q;
  fefp_pkg::fefp_load_t ld_d;
  wire logic            load_done;

  assign load_done = (ld_q == fefp_pkg::LD_WAIT) & i_cfg_rsp.valid;

  always_comb begin
    case (ld_q)
      fefp_pkg::LD_REQ: begin
        ld_d = fefp_pkg::LD_WAIT;
      end
      fefp_pkg::LD_WAIT: begin
        ld_d = i_cfg_rsp.valid ? fefp_pkg::LD_RUN : fefp_pkg::LD_WAIT;
      end
      fefp_pkg::LD_RUN: begin
        ld_d = fefp_pkg::LD_RUN;
      end
      default: begin
        ld_d = fefp_pkg::LD_REQ;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ld_q <= fefp_pkg::LD_REQ;
    end else begin
      ld_q <= ld_d;
    end
  end

  assign o_cfg_rd_req  = (ld_q == fefp_pkg::LD_REQ);
  assign o_cfg_rd_addr = fefp_pkg::CFG_PROT_ADDR;
  assign o_prot_loaded = (ld_q == fefp_pkg::LD_RUN);

  // ==========================================================================
  // region protection register
  logic [fefp_pkg::DATA_W-1:0] prot_q;
  wire logic [fefp_pkg::DATA_W-1:0] prot_wr_val;
  wire logic [fefp_pkg::DATA_W-1:0] prot_ld_val;
  wire logic                        prot_wr_ok;

  assign prot_wr_val = {i_wdata[fefp_pkg::BIT_PROT_OPEN],
                        prot_q[fefp_pkg::BIT_PROT_RSV],
                        i_wdata[fefp_pkg::BIT_HI_DIS:0]};
  assign prot_ld_val = i_cfg_rsp.double_err ? fefp_pkg::PROT_FAULT_VAL : i_cfg_rsp.data;
  assign prot_wr_ok  = wr_prot & o_prot_loaded & prot_grows(prot_q, prot_wr_val);

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prot_q <= fefp_pkg::REGION_PROT_RST;
    end else if (load_done) begin
      prot_q <= prot_ld_val;
    end else if (prot_wr_ok) begin
      prot_q <= prot_wr_val;
    end
  end

  assign o_region_protect = prot_q;

  // ==========================================================================
  // read path
  logic [fefp_pkg::DATA_W-1:0] rdata_q;
  logic [fefp_pkg::DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (sel_config) begin
      rd_mux[fefp_pkg::BIT_IGNORE_SF] = ignore_sf_q;
    end else if (sel_err_cfg) begin
      rd_mux[fefp_pkg::FAULT_W-1:0] = irq_en_q;
    end else if (sel_status) begin
      rd_mux[fefp_pkg::FAULT_W-1:0] = flags;
    end else if (sel_prot) begin
      rd_mux = prot_q;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= i_rd ? rd_mux : '0;
    end
  end

  assign o_rdata = rdata_q;

endmodule

/* File: tb/fefp_chk.sv */
// checker: port-level properties of the flash fault and protection block
`timescale 1ns/1ps
module fefp_chk (
  input wire logic                        i_clk,
  input wire logic                        i_arst_n,
  input wire logic [fefp_pkg::ADDR_W-1:0] i_addr,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic [fefp_pkg::DATA_W-1:0] o_rdata,
  input wire fefp_pkg::fefp_rd_rpt_t      i_rd_rpt,
  input wire logic                        o_cfg_rd_req,
  input wire logic [17:0]                 o_cfg_rd_addr,
  input wire fefp_pkg::fefp_cfg_rsp_t     i_cfg_rsp,
  input wire logic [fefp_pkg::DATA_W-1:0] o_region_protect,
  input wire logic                        o_prot_loaded,
  input wire logic                        o_irq
);
  // ==========================================================================
  // helpers
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire ld_ok = i_cfg_rsp.valid && !o_cfg_rd_req && !o_prot_loaded;
  wire pw_hit = i_wr && (i_addr == fefp_pkg::OFS_REGION_PROT);

  // ==========================================================================
  // properties
  a_rdata_idle_zero:
    assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside slot");
  a_status_high_zero:
    assert property ($past(i_rd && i_addr == fefp_pkg::OFS_FAULT_STATUS) |-> o_rdata[7:2] == 6'h00)
    else $error("status high bits set");
  a_cfg_addr_fixed:
    assert property (o_cfg_rd_addr == fefp_pkg::CFG_PROT_ADDR) else $error("config address wrong");
  a_load_value:
    assert property (ld_ok && !i_cfg_rsp.double_err |=> o_prot_loaded && o_region_protect == $past(i_cfg_rsp.data))
    else $error("protection load wrong");
  a_load_fault_lock:
    assert property (ld_ok && i_cfg_rsp.double_err |=> o_prot_loaded && o_region_protect == fefp_pkg::PROT_FAULT_VAL)
    else $error("fault load not locked");
  a_prot_hold:
    assert property (o_prot_loaded && !pw_hit |=> $stable(o_region_protect)) else $error("protection changed");
  a_prot_no_shrink:
    assert property (o_prot_loaded && o_region_protect[7] && !o_region_protect[5] |=> (o_region_protect[7]
      && !o_region_protect[5] && o_region_protect[4:3] >= $past(o_region_protect[4:3]))
      || (!o_region_protect[7] && o_region_protect[5] && o_region_protect[2]))
    else $error("protection shrank");
  a_irq_cause:
    assert property ($rose(o_irq) |-> $past(i_rd_rpt.valid, 2) || $past(i_wr)) else $error("irq without cause");
endmodule

bind fefp_top fefp_chk i_fefp_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_rd_rpt(i_rd_rpt), .o_cfg_rd_req(o_cfg_rd_req), .o_cfg_rd_addr(o_cfg_rd_addr), .i_cfg_rsp(i_cfg_rsp),
  .o_region_protect(o_region_protect), .o_prot_loaded(o_prot_loaded), .o_irq(o_irq)
);

/* File: tb/fefp_top_tb.sv */
// testbench: register, fault report and protection load scenarios
`timescale 1ns/1ps
module fefp_top_tb;
  logic                        i_clk;
  logic                        i_arst_n;
  logic [fefp_pkg::ADDR_W-1:0] i_addr;
  logic [fefp_pkg::DATA_W-1:0] i_wdata;
  logic                        i_wr;
  logic                        i_rd;
  logic [fefp_pkg::DATA_W-1:0] o_rdata;
  fefp_pkg::fefp_rd_rpt_t      i_rd_rpt;
  logic                        o_cfg_rd_req;
  logic [17:0]                 o_cfg_rd_addr;
  fefp_pkg::fefp_cfg_rsp_t     i_cfg_rsp;
  logic [fefp_pkg::DATA_W-1:0] o_region_protect;
  logic                        o_prot_loaded;
  logic                        o_irq;
  int                          errors;
  int                          samples_checked;
  int                          cycles;
  logic [3:0]                  rpt_tab [6] = '{4'ha, 4'hc, 4'he, 4'h9, 4'hc, 4'h9};
  logic [7:0]                  ign_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h10};
  logic [7:0]                  exp_tab [6] = '{8'h02, 8'h01, 8'h02, 8'h03, 8'h00, 8'h03};
  logic [7:0]                  pw_tab [5] = '{8'h85, 8'ha5, 8'h8d, 8'h85, 8'hcd};
  logic [7:0]                  pe_tab [5] = '{8'h85, 8'h85, 8'h8d, 8'h8d, 8'h8d};

  fefp_top i_fefp_top (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_rd_rpt(i_rd_rpt), .o_cfg_rd_req(o_cfg_rd_req), .o_cfg_rd_addr(o_cfg_rd_addr),
    .i_cfg_rsp(i_cfg_rsp), .o_region_protect(o_region_protect), .o_prot_loaded(o_prot_loaded), .o_irq(o_irq)
  );

  // ==========================================================================
  // clock and timeout
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end

  // ==========================================================================
  // tasks
  task automatic test_done();
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic rpt(input logic [3:0] r);
    @(posedge i_clk);
    i_rd_rpt <= fefp_pkg::fefp_rd_rpt_t'(r);
    @(posedge i_clk);
    i_rd_rpt <= '0;
  endtask
  task automatic rst(input logic dbl, input logic [7:0] d);
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk({7'h00, o_cfg_rd_req}, 8'h01);
    i_arst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_cfg_rsp <= {1'b1, dbl, d};
    @(posedge i_clk);
    i_cfg_rsp <= {1'b0, 1'b0, ~d};
    @(posedge i_clk);
    #1;
    chk({7'h00, o_prot_loaded}, 8'h01);
    chk(o_region_protect, dbl ? fefp_pkg::PROT_FAULT_VAL : d);
    chk({7'h00, o_cfg_rd_req}, 8'h00);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    i_arst_n = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_rd_rpt = '0;
    i_cfg_rsp = '0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    rst(1'b0, 8'ha5);
    rd(fefp_pkg::OFS_FAULT_STATUS, 8'h00);
    rd(5'h1f, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(fefp_pkg::OFS_REGION_PROT, pw_tab[i]);
      rd(fefp_pkg::OFS_REGION_PROT, pe_tab[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(fefp_pkg::OFS_FLASH_CONFIG, ign_tab[i]);
      rpt(rpt_tab[i]);
      rd(fefp_pkg::OFS_FAULT_STATUS, exp_tab[i]);
      wr(fefp_pkg::OFS_FAULT_STATUS, 8'hff);
      rd(fefp_pkg::OFS_FAULT_STATUS, 8'h00);
    end
    wr(fefp_pkg::OFS_FLASH_CONFIG, 8'h00);
    wr(fefp_pkg::OFS_ERR_CONFIG, 8'h01);
    rpt(4'ha);
    rd(fefp_pkg::OFS_FAULT_STATUS, 8'h02);
    chk({7'h00, o_irq}, 8'h00);
    wr(fefp_pkg::OFS_FAULT_STATUS, 8'h01);
    rd(fefp_pkg::OFS_FAULT_STATUS, 8'h02);
    wr(fefp_pkg::OFS_ERR_CONFIG, 8'h03);
    #1;
    chk({7'h00, o_irq}, 8'h01);
    wr(fefp_pkg::OFS_FAULT_STATUS, 8'h02);
    #1;
    chk({7'h00, o_irq}, 8'h00);
    rpt(4'hc);
    #1;
    chk({7'h00, o_irq}, 8'h00);
    rd(fefp_pkg::OFS_FAULT_STATUS, 8'h01);
    chk({7'h00, o_irq}, 8'h01);
    wr(fefp_pkg::OFS_FAULT_STATUS, 8'h02);
    rd(fefp_pkg::OFS_FAULT_STATUS, 8'h01);
    wr(fefp_pkg::OFS_FAULT_STATUS, 8'h01);
    rd(fefp_pkg::OFS_FAULT_STATUS, 8'h00);
    rst(1'b1, 8'h00);
    wr(fefp_pkg::OFS_REGION_PROT, 8'hff);
    rd(fefp_pkg::OFS_REGION_PROT, fefp_pkg::PROT_FAULT_VAL);
    rd(fefp_pkg::OFS_FAULT_STATUS, 8'h00);
    test_done();
  end
endmodule
